// >>> core/pmc_ctrl.sv
// Purpose: Power mode sequencer with AXI4-Lite register access
// Assumes: Inputs synchronous to i_core_clk; i_nrst is power-on reset
// Notes: Wake latencies are upper bounds in core clock cycles
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pmc_ctrl #(
   parameter int unsigned STBY_CYC = pmc_pkg::STBY_WAKE_CYC,
   parameter int unsigned SHDN_CYC = pmc_pkg::SHDN_WAKE_CYC
) (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [7:0] i_awaddr,
   input wire logic i_wvalid,
   output logic o_wready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   output logic o_bvalid,
   input wire logic i_bready,
   output logic [1:0] o_bresp,
   input wire logic i_arvalid,
   output logic o_arready,
   input wire logic [7:0] i_araddr,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   input wire logic i_irq_any,
   input wire logic i_ext_wake,
   input wire logic i_rtc_evt,
   input wire logic i_sensor_evt,
   input wire logic i_rst_pin_n,
   input wire logic [pmc_pkg::NGPIO-1:0] i_gpio,
   input wire logic i_recharge,
   input wire logic i_supply_low,
   output pmc_pkg::pmc_clk_s o_clk_en,
   output pmc_pkg::pmc_pwr_s o_pwr_en,
   output pmc_pkg::pmc_osc_s o_osc,
   output logic o_io_hold,
   output logic [pmc_pkg::NRAM-1:0] o_ram_ret,
   output logic o_cache_as_ram,
   output logic o_drop_det_en,
   output logic o_sys_rst,
   output logic o_cpu_resume
);
   localparam int A_IDLE_MAX = 702;
   pmc_pkg::pmc_state_e st_q, st_d;
   pmc_pkg::pmc_mode_e tgt_q, tgt_d;
   logic boot_q, from_stby_q, lock_q, wake_go, wake_boot, tmr_done;
   logic [2:0] cause_q;
   logic [4:0] ramret_q;
   logic [2:0] clkcfg_q;
   logic [1:0] wakecfg_q;
   logic [15:0] wkpin_q, snap_q;
   logic [pmc_pkg::TMR_W-1:0] tmr_cnt;
   logic aw_q, w_q, wr_go, mode_wr, stby_wake, shdn_wake, strb0_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;

   // Address decode shared by both bus directions
   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a[1:0] == 2'h0) && (a[7:2] < 6'(pmc_pkg::NUM_REGS));
   endfunction

   // Write address and data taken in either order
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
         strb0_q <= 1'b0;
      end else if (wr_go) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
      end else begin
         if (i_awvalid && o_awready) begin
            aw_q <= 1'b1;
            awaddr_q <= i_awaddr;
         end
         if (i_wvalid && o_wready) begin
            w_q <= 1'b1;
            wdata_q <= i_wdata;
            strb0_q <= i_wstrb[0]; // Strobe belongs to the data beat
         end
      end
   end

   assign o_awready = !aw_q && !o_bvalid;
   assign o_wready = !w_q && !o_bvalid;
   assign wr_go = aw_q && w_q;
   // Low byte lane carries every field of the mode request
   assign mode_wr = wr_go && awaddr_q == pmc_pkg::OFS_MODE && strb0_q;

   // Write response; unmapped addresses get SLVERR
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         o_bvalid <= 1'b0;
         o_bresp <= pmc_pkg::RESP_OKAY;
      end else if (wr_go) begin
         o_bvalid <= 1'b1;
         o_bresp <= reg_hit(awaddr_q) ? pmc_pkg::RESP_OKAY
                                      : pmc_pkg::RESP_SLVERR;
      end else if (i_bready) begin
         o_bvalid <= 1'b0;
      end
   end

   // Read channel answers one cycle after the address
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         o_rvalid <= 1'b0;
         o_rdata <= 32'h00000000;
         o_rresp <= pmc_pkg::RESP_OKAY;
      end else if (i_arvalid && o_arready) begin
         o_rvalid <= 1'b1;
         o_rresp <= reg_hit(i_araddr) ? pmc_pkg::RESP_OKAY
                                      : pmc_pkg::RESP_SLVERR;
         case (i_araddr)
            pmc_pkg::OFS_MODE: o_rdata <= {29'h0, tgt_q};
            pmc_pkg::OFS_STATUS: o_rdata <= {27'h0, lock_q, st_q};
            pmc_pkg::OFS_CAUSE: o_rdata <= {29'h0, cause_q};
            pmc_pkg::OFS_RAMRET: o_rdata <= {27'h0, ramret_q};
            pmc_pkg::OFS_CLK: o_rdata <= {29'h0, clkcfg_q};
            pmc_pkg::OFS_WAKE: o_rdata <= {30'h0, wakecfg_q};
            pmc_pkg::OFS_WKPIN: o_rdata <= {16'h0, wkpin_q};
            default: o_rdata <= 32'h00000000;
         endcase
      end else if (i_rready) begin
         o_rvalid <= 1'b0;
      end
   end

   assign o_arready = !o_rvalid;

   // Config registers; a boot wipes them as power loss would
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst || (wake_go && wake_boot)) begin
         ramret_q <= pmc_pkg::RAMRET_RST;
         clkcfg_q <= pmc_pkg::CLK_RST;
         wakecfg_q <= pmc_pkg::WAKE_RST;
         wkpin_q <= pmc_pkg::WKPIN_RST;
      end else if (wr_go) begin
         case (awaddr_q)
            pmc_pkg::OFS_RAMRET: ramret_q <= wdata_q[4:0];
            pmc_pkg::OFS_CLK: clkcfg_q <= wdata_q[2:0];
            pmc_pkg::OFS_WAKE: wakecfg_q <= wdata_q[1:0];
            pmc_pkg::OFS_WKPIN: wkpin_q <= wdata_q[15:0];
            default: ;
         endcase
      end
   end

   // Reset cause: write one to clear, a new cause wins over the clear
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         cause_q <= pmc_pkg::CAUSE_RST;
      end else if (wake_go && wake_boot) begin
         cause_q[pmc_pkg::CAUSE_POR] <= 1'b0;
         cause_q[pmc_pkg::CAUSE_PIN] <= !i_rst_pin_n;
         cause_q[pmc_pkg::CAUSE_WKP] <= i_rst_pin_n;
      end else if (wr_go && awaddr_q == pmc_pkg::OFS_CAUSE) begin
         cause_q <= cause_q & ~wdata_q[2:0];
      end
   end

   // Wake sources per mode
   assign stby_wake = i_ext_wake
      || (i_rtc_evt && wakecfg_q[pmc_pkg::WK_RTC])
      || (i_sensor_evt && wakecfg_q[pmc_pkg::WK_SENS]);
   assign shdn_wake = |((i_gpio ^ snap_q) & wkpin_q);

   // Next state; reset pin overrides every mode
   always_comb begin
      st_d = st_q;
      tgt_d = tgt_q;
      wake_go = 1'b0;
      wake_boot = 1'b0;
      if (!i_rst_pin_n) begin
         st_d = pmc_pkg::ST_WAKE;
         wake_go = 1'b1;
         wake_boot = 1'b1;
      end else begin
         case (st_q)
            pmc_pkg::ST_ACTIVE: begin
               if (mode_wr) begin
                  case (wdata_q[2:0])
                     pmc_pkg::MD_IDLE: st_d = pmc_pkg::ST_IDLE;
                     pmc_pkg::MD_STBY, pmc_pkg::MD_SHDN,
                     pmc_pkg::MD_HELD: begin
                        st_d = pmc_pkg::ST_GATE;
                        tgt_d = pmc_pkg::pmc_mode_e'(wdata_q[2:0]);
                     end
                     default: ;
                  endcase
               end
            end
            pmc_pkg::ST_IDLE: begin
               if (i_irq_any) begin
                  st_d = pmc_pkg::ST_WAKE;
                  wake_go = 1'b1;
               end
            end
            pmc_pkg::ST_GATE: st_d = pmc_pkg::ST_LATCH;
            pmc_pkg::ST_LATCH: begin
               case (tgt_q)
                  pmc_pkg::MD_STBY: st_d = pmc_pkg::ST_STBY;
                  pmc_pkg::MD_SHDN: st_d = pmc_pkg::ST_SHDN;
                  default: st_d = pmc_pkg::ST_HELD;
               endcase
            end
            pmc_pkg::ST_STBY: begin
               if (stby_wake) begin
                  st_d = pmc_pkg::ST_WAKE;
                  wake_go = 1'b1;
               end
            end
            pmc_pkg::ST_SHDN: begin
               if (shdn_wake) begin
                  st_d = pmc_pkg::ST_WAKE;
                  wake_go = 1'b1;
                  wake_boot = 1'b1;
               end
            end
            pmc_pkg::ST_WAKE: begin
               if (tmr_done) begin
                  st_d = (lock_q && !boot_q) ? pmc_pkg::ST_LOCKED
                                             : pmc_pkg::ST_UNLATCH;
               end
            end
            pmc_pkg::ST_UNLATCH: begin
               st_d = pmc_pkg::ST_ACTIVE;
               tgt_d = pmc_pkg::MD_ACTIVE;
            end
            default: ; // Held and locked leave only by reset pin
         endcase
      end
   end

   // State and wake bookkeeping
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         st_q <= pmc_pkg::ST_ACTIVE;
         tgt_q <= pmc_pkg::MD_ACTIVE;
         boot_q <= 1'b0;
         from_stby_q <= 1'b0;
      end else begin
         st_q <= st_d;
         tgt_q <= tgt_d;
         if (wake_go) begin
            boot_q <= wake_boot;
            from_stby_q <= st_q == pmc_pkg::ST_STBY;
         end
      end
   end

   // Pin image taken as the I/O latches close
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         snap_q <= 16'h0000;
      end else if (st_q == pmc_pkg::ST_GATE) begin
         snap_q <= i_gpio;
      end
   end

   // Dip seen while the detector sleeps locks the next wake
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst || (wake_go && wake_boot)) begin
         lock_q <= 1'b0;
      end else if (st_q == pmc_pkg::ST_STBY && !i_recharge
                   && i_supply_low) begin
         lock_q <= 1'b1;
      end
   end

   // Latency by source mode; reset-type wakes take the longest
   always_comb begin
      if (wake_boot) begin
         tmr_cnt = pmc_pkg::TMR_W'(SHDN_CYC - 1);
      end else if (st_q == pmc_pkg::ST_STBY) begin
         tmr_cnt = pmc_pkg::TMR_W'(STBY_CYC - 1);
      end else begin
         tmr_cnt = pmc_pkg::TMR_W'(pmc_pkg::IDLE_WAKE_CYC - 1);
      end
   end

   pmc_wake_timer u_tmr (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_load(wake_go),
      .i_count(tmr_cnt),
      .o_done(tmr_done)
   );

   // Domain controls decoded from state; power returns before clocks
   always_comb begin
      o_clk_en.cpu = st_q == pmc_pkg::ST_ACTIVE;
      o_clk_en.mem = st_q == pmc_pkg::ST_ACTIVE;
      o_clk_en.periph = st_q == pmc_pkg::ST_ACTIVE
                        || st_q == pmc_pkg::ST_IDLE;
      o_io_hold = st_q inside {pmc_pkg::ST_LATCH, pmc_pkg::ST_STBY,
                               pmc_pkg::ST_SHDN, pmc_pkg::ST_HELD,
                               pmc_pkg::ST_WAKE, pmc_pkg::ST_LOCKED};
      o_pwr_en.core = !(st_q inside {pmc_pkg::ST_STBY, pmc_pkg::ST_SHDN,
                                     pmc_pkg::ST_HELD});
      o_pwr_en.flash = o_pwr_en.core;
      o_pwr_en.always_on_domain = !(st_q inside {pmc_pkg::ST_SHDN,
                                    pmc_pkg::ST_HELD});
      o_pwr_en.sensor = o_pwr_en.always_on_domain;
      o_drop_det_en = o_pwr_en.core
                      || (st_q == pmc_pkg::ST_STBY && i_recharge);
      o_sys_rst = boot_q && (st_q == pmc_pkg::ST_WAKE
                             || st_q == pmc_pkg::ST_UNLATCH);
      o_cpu_resume = st_q == pmc_pkg::ST_UNLATCH && !boot_q
                     && from_stby_q;
   end

   // Retention and clock steering from software settings
   genvar gi;
   generate
      for (gi = 0; gi < pmc_pkg::NRAM; gi++) begin : g_ret
         assign o_ram_ret[gi] = ramret_q[gi] && o_pwr_en.always_on_domain;
      end
   endgenerate
   assign o_cache_as_ram = ramret_q[pmc_pkg::RET_CACHE_RAM];
   assign o_osc.hf_xtal = clkcfg_q[pmc_pkg::CLK_HF_XTAL]
                          && o_pwr_en.core;
   assign o_osc.hf_dbl = o_osc.hf_xtal;
   assign o_osc.lf_xtal = clkcfg_q[pmc_pkg::CLK_LF_XTAL];
   assign o_osc.lf_out = clkcfg_q[pmc_pkg::CLK_LF_OUT]
                         && o_pwr_en.always_on_domain;

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);

   sequence s_restore;
      st_q == pmc_pkg::ST_UNLATCH && !o_io_hold ##1
      st_q == pmc_pkg::ST_ACTIVE && o_clk_en.cpu;
   endsequence
   sequence s_power_down;
      st_q == pmc_pkg::ST_GATE && !o_clk_en.cpu && o_pwr_en.core ##1
      o_io_hold && o_pwr_en.core ##1 !o_pwr_en.core;
   endsequence

   a_idle_irq_wake: assert property (
      st_q == pmc_pkg::ST_IDLE && i_irq_any && i_rst_pin_n
      |=> st_q == pmc_pkg::ST_WAKE) else $error("idle irq not taken");
   a_idle_latency: assert property (
      $rose(st_q == pmc_pkg::ST_WAKE) && !boot_q && !from_stby_q
      |-> ##[1:A_IDLE_MAX] st_q == pmc_pkg::ST_ACTIVE
         || !i_rst_pin_n) else $error("idle wake too slow");
   a_entry_order: assert property (
      disable iff (!i_nrst || !i_rst_pin_n)
      st_q == pmc_pkg::ST_ACTIVE && mode_wr && i_rst_pin_n
      && wdata_q[2:0] == pmc_pkg::MD_STBY
      |=> s_power_down)
      else $error("power down order wrong");
   a_wake_order: assert property (
      disable iff (!i_nrst || !i_rst_pin_n)
      st_q == pmc_pkg::ST_WAKE && tmr_done && i_rst_pin_n && !lock_q
      |=> s_restore) else $error("wake restore order wrong");
   a_stby_hold: assert property (
      st_q == pmc_pkg::ST_STBY |-> o_io_hold && !o_pwr_en.core
      && o_pwr_en.always_on_domain) else $error("standby domains wrong");
   a_shdn_off: assert property (
      st_q == pmc_pkg::ST_SHDN |-> o_io_hold && !o_pwr_en.always_on_domain
      && !o_pwr_en.sensor) else $error("shutdown domains wrong");
   a_held_only_pin: assert property (
      st_q == pmc_pkg::ST_HELD && i_rst_pin_n |=> st_q == pmc_pkg::ST_HELD)
      else $error("held left without reset pin");
   a_pin_cause: assert property (
      !i_rst_pin_n |=> cause_q[pmc_pkg::CAUSE_PIN] && o_sys_rst
      && st_q == pmc_pkg::ST_WAKE) else $error("reset pin cause lost");
   a_wkp_reset: assert property (
      st_q == pmc_pkg::ST_SHDN && shdn_wake && i_rst_pin_n
      |=> cause_q[pmc_pkg::CAUSE_WKP] && o_sys_rst && wkpin_q == 16'h0000)
      else $error("wake pin not a reset");
   a_lock_stays: assert property (
      st_q == pmc_pkg::ST_LOCKED && i_rst_pin_n
      |=> st_q == pmc_pkg::ST_LOCKED) else $error("lock released");
endmodule // pmc_ctrl

// >>> inc/pmc_pkg.sv
// Purpose: Shared constants and types for the power mode controller
// Assumes: 50 MHz core clock, AXI4-Lite register access, 32-bit data
// Notes: Wake latency counts derive from the times in ns below
package pmc_pkg;
   // Sequencer states
   typedef enum logic [3:0] {
      ST_ACTIVE  = 4'h0,
      ST_IDLE    = 4'h1,
      ST_GATE    = 4'h2,
      ST_LATCH   = 4'h3,
      ST_STBY    = 4'h4,
      ST_SHDN    = 4'h5,
      ST_HELD    = 4'h6,
      ST_WAKE    = 4'h7,
      ST_UNLATCH = 4'h8,
      ST_LOCKED  = 4'h9
   } pmc_state_e;
   // Modes software may request
   typedef enum logic [2:0] {
      MD_ACTIVE = 3'h0,
      MD_IDLE   = 3'h1,
      MD_STBY   = 3'h2,
      MD_SHDN   = 3'h3,
      MD_HELD   = 3'h4
   } pmc_mode_e;
   typedef struct packed {logic cpu; logic mem; logic periph;} pmc_clk_s;
   typedef struct packed {
      logic core; logic flash; logic always_on_domain; logic sensor;
   } pmc_pwr_s;
   typedef struct packed {
      logic hf_xtal; logic hf_dbl; logic lf_xtal; logic lf_out;
   } pmc_osc_s;
   // Register byte offsets
   localparam logic [7:0] OFS_MODE   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_CAUSE  = 8'h08;
   localparam logic [7:0] OFS_RAMRET = 8'h0C;
   localparam logic [7:0] OFS_CLK    = 8'h10;
   localparam logic [7:0] OFS_WAKE   = 8'h14;
   localparam logic [7:0] OFS_WKPIN  = 8'h18;
   localparam int NUM_REGS = 7;
   // Field positions
   localparam int CAUSE_POR = 0;
   localparam int CAUSE_PIN = 1;
   localparam int CAUSE_WKP = 2;
   localparam int CLK_HF_XTAL = 0;
   localparam int CLK_LF_XTAL = 1;
   localparam int CLK_LF_OUT = 2;
   localparam int WK_RTC = 0;
   localparam int WK_SENS = 1;
   localparam int RET_CACHE_RAM = 4;
   localparam int STS_LOCK = 4;
   // Reset values, response codes and sizes
   localparam logic [2:0] CAUSE_RST = 3'h1;
   localparam logic [4:0] RAMRET_RST = 5'h0F;
   localparam logic [2:0] CLK_RST = 3'h0;
   localparam logic [1:0] WAKE_RST = 2'h3;
   localparam logic [15:0] WKPIN_RST = 16'h0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int NGPIO = 16;
   localparam int NRAM = 4;
   // Wake timing
   localparam int CLK_MHZ = 50;
   localparam int IDLE_WAKE_NS = 14000;
   localparam int STBY_WAKE_NS = 151000;
   localparam int SHDN_WAKE_NS = 1015000;
   localparam int IDLE_WAKE_CYC = IDLE_WAKE_NS * CLK_MHZ / 1000;
   localparam int STBY_WAKE_CYC = STBY_WAKE_NS * CLK_MHZ / 1000;
   localparam int SHDN_WAKE_CYC = SHDN_WAKE_NS * CLK_MHZ / 1000;
   localparam int TMR_W = 16;
endpackage

// >>> core/pmc_wake_timer.sv
// Purpose: Down counter timing the wake-up latency
// Assumes: Count of at least 2 on load
// Notes: Reload while busy restarts the count
`timescale 1ns/1ps
module pmc_wake_timer (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_load,
   input wire logic [pmc_pkg::TMR_W-1:0] i_count,
   output logic o_done
);
   logic [pmc_pkg::TMR_W-1:0] cnt_q;
   logic busy_q;

   // Count down; done on the last cycle of the wait
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         cnt_q <= 16'h0000;
         busy_q <= 1'b0;
      end else if (i_load) begin
         cnt_q <= i_count;
         busy_q <= 1'b1;
      end else if (busy_q) begin
         cnt_q <= cnt_q - 16'h0001;
         busy_q <= (cnt_q != 16'h0001);
      end
   end

   assign o_done = busy_q && (cnt_q == 16'h0001) && !i_load;
endmodule // pmc_wake_timer

// >>> bench/pmc_pins_model.sv
// Purpose: Far side of the sequencer: wake sources, reset pin, GPIO, supply
// Assumes: Tasks are called just after a rising edge of the core clock
// Notes: Every change is a non-blocking update on that edge
`timescale 1ns/1ps
module pmc_pins_model (
   input wire logic i_core_clk,
   output logic o_irq_any,
   output logic o_ext_wake,
   output logic o_rtc_evt,
   output logic o_sensor_evt,
   output logic o_rst_pin_n,
   output logic [pmc_pkg::NGPIO-1:0] o_gpio,
   output logic o_recharge,
   output logic o_supply_low
);
   logic [3:0] ev = 4'h0;
   // Event lines: 0 interrupt, 1 external, 2 timer, 3 sensor
   assign {o_sensor_evt, o_rtc_evt, o_ext_wake, o_irq_any} = ev;
   // Quiet pins, supply inside its range
   initial begin
      o_rst_pin_n = 1'b1;
      o_gpio = 16'h00A5;
      o_recharge = 1'b1;
      o_supply_low = 1'b0;
   end
   // One-cycle event, sampled by the edge that ends it
   task automatic pulse(input int k);
      ev[k] <= 1'b1;
      @(posedge i_core_clk);
      ev <= 4'h0;
   endtask
   // Reset pin low for two edges
   task automatic rst_pin();
      o_rst_pin_n <= 1'b0;
      repeat (2) @(posedge i_core_clk);
      o_rst_pin_n <= 1'b1;
   endtask
   // Level change on one pin
   task automatic flip(input int k);
      o_gpio[k] <= ~o_gpio[k];
   endtask
   // Supply dips only when a test asks; software keeps clear otherwise
   task automatic supply(input logic rech, input logic low);
      o_recharge <= rech;
      o_supply_low <= low;
   endtask
endmodule // pmc_pins_model

// >>> bench/pmc_ctrl_tb_top.sv
// Purpose: Self-checking bench for the power mode sequencer
// Assumes: Short wake counts of 20 and 30 cycles for standby and reset
// Notes: Registers reached only over the AXI4-Lite tasks below
`timescale 1ns/1ps
module pmc_ctrl_tb_top;
   localparam int SB = 20;
   localparam int SD = 30;
   localparam int ID = pmc_pkg::IDLE_WAKE_CYC;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic [3:0] strb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic irq, ext, rtc, sens, rpin, rech, slow, hold, cram, ddet, srst, res;
   logic [15:0] gpio;
   logic [3:0] ret;
   pmc_pkg::pmc_clk_s ce;
   pmc_pkg::pmc_pwr_s pw;
   pmc_pkg::pmc_osc_s osc;
   int n_fail = 0, n_tests = 0, n_res = 0, n_rst = 0, c;
   always #10 clk = ~clk;
   pmc_ctrl #(.STBY_CYC(SB), .SHDN_CYC(SD)) dut_u (.i_core_clk(clk),
      .i_nrst(nrst), .i_awvalid(awvalid), .o_awready(awready),
      .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
      .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid),
      .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid),
      .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
      .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
      .i_irq_any(irq), .i_ext_wake(ext), .i_rtc_evt(rtc),
      .i_sensor_evt(sens), .i_rst_pin_n(rpin), .i_gpio(gpio),
      .i_recharge(rech), .i_supply_low(slow), .o_clk_en(ce),
      .o_pwr_en(pw), .o_osc(osc), .o_io_hold(hold), .o_ram_ret(ret),
      .o_cache_as_ram(cram), .o_drop_det_en(ddet), .o_sys_rst(srst),
      .o_cpu_resume(res));
   pmc_pins_model pins_u (.i_core_clk(clk), .o_irq_any(irq),
      .o_ext_wake(ext), .o_rtc_evt(rtc), .o_sensor_evt(sens),
      .o_rst_pin_n(rpin), .o_gpio(gpio), .o_recharge(rech),
      .o_supply_low(slow));
   // Resume pulses and reset-held cycles, cleared by the tests
   always @(posedge clk) begin
      if (res === 1'b1) n_res++;
      if (srst === 1'b1) n_rst++;
   end
   task automatic chk(input string s, input logic [31:0] e,
                      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("wrong value %s exp %h got %h", s, e, g);
         n_fail++;
      end
   endtask
   // Write: both channels offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      awaddr <= a;
      wdata <= d;
      wstrb <= strb;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge clk);
         if (awready === 1'b1) aw = 1'b1;
         if (wready === 1'b1) w = 1'b1;
         awvalid <= !aw;
         wvalid <= !w;
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      chk("bresp", {30'h0, er}, {30'h0, bresp});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      chk("rdata", e, rdata);
      chk("rresp", {30'h0, er}, {30'h0, rresp});
   endtask
   // Mode request; clocks stop while power and pins are untouched
   task automatic go(input logic [31:0] m);
      wr(pmc_pkg::OFS_MODE, m, 2'h0);
      // Looked at in the gate state itself (idle state for an idle request), before the pins latch
      while (ce.cpu !== 1'b0) @(posedge clk);
      chk("gate_hold", 32'h0, 32'(hold));
      chk("gate_core", 32'h1, 32'(pw.core));
      if (m > 1) begin
         do @(posedge clk); while (hold !== 1'b1);
         repeat (2) @(posedge clk);
      end
   endtask
   // Cycles from the wake cause until the processor clock returns
   task automatic wake(input int n);
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while (ce.cpu !== 1'b1);
      chk("wake_time", 32'h1, 32'(c >= n - 1 && c <= n + 3));
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Hang guard, well beyond the idle wake plus all short waits
   initial begin
      #(30000 * 20);
      n_fail++;
      close_out();
   end
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      chk("clk_en", 32'h7, 32'(ce));
      chk("pwr_en", 32'hF, 32'(pw));
      rd(pmc_pkg::OFS_CAUSE, 32'h1, 2'h0);
      rd(pmc_pkg::OFS_RAMRET, 32'hF, 2'h0);
      rd(pmc_pkg::OFS_WAKE, 32'h3, 2'h0);
      rd(8'h1C, 32'h0, 2'h2);
      wr(8'hFC, 32'hFF, 2'h2);
      // Clock sources and cache as RAM
      wr(pmc_pkg::OFS_CLK, 32'h7, 2'h0);
      chk("osc", 32'hF, 32'(osc));
      wr(pmc_pkg::OFS_CLK, 32'h5, 2'h0);
      chk("osc", 32'hD, 32'(osc));
      wr(pmc_pkg::OFS_RAMRET, 32'h15, 2'h0);
      chk("cache_ram", 32'h1, 32'(cram));
      // Mode request without the low byte lane must be ignored
      strb = 4'hE;
      wr(pmc_pkg::OFS_MODE, 32'h1, 2'h0);
      strb = 4'hF;
      chk("strb_ign", 32'h7, 32'(ce));
      // Idle: peripheral clock only, interrupt wakes
      go(32'h1);
      repeat (3) @(posedge clk);
      chk("idle_clk", 32'h1, 32'(ce));
      pins_u.pulse(0);
      wake(ID);
      // Standby: timer wake masked off, sensor wake resumes
      wr(pmc_pkg::OFS_WAKE, 32'h2, 2'h0);
      go(32'h2);
      chk("stby_pwr", 32'h3, 32'(pw));
      chk("stby_ret", 32'h5, 32'(ret));
      chk("stby_hold", 32'h1, 32'(hold));
      wr(pmc_pkg::OFS_MODE, 32'h0, 2'h0);
      pins_u.pulse(2);
      repeat (SB + 5) @(posedge clk);
      chk("masked", 32'h1, 32'(hold));
      n_res = 0;
      n_rst = 0;
      pins_u.pulse(3);
      wake(SB);
      chk("resume", 32'h1, 32'(n_res));
      chk("no_rst", 32'h0, 32'(n_rst));
      rd(pmc_pkg::OFS_RAMRET, 32'h15, 2'h0);
      // Supply dip between recharges locks the next wake
      go(32'h2);
      chk("det_on", 32'h1, 32'(ddet));
      pins_u.supply(1'b0, 1'b1);
      repeat (2) @(posedge clk);
      chk("det_off", 32'h0, 32'(ddet));
      pins_u.supply(1'b1, 1'b0);
      pins_u.pulse(1);
      repeat (SB + 8) @(posedge clk);
      chk("locked", 32'h0, 32'(ce.cpu));
      rd(pmc_pkg::OFS_STATUS, 32'h19, 2'h0);
      pins_u.rst_pin();
      wake(SD);
      rd(pmc_pkg::OFS_CAUSE, 32'h2, 2'h0);
      // Shutdown: pin change wakes as a reset and clears settings
      wr(pmc_pkg::OFS_WKPIN, 32'h1, 2'h0);
      go(32'h3);
      chk("shdn_pwr", 32'h0, 32'(pw));
      chk("shdn_hold", 32'h1, 32'(hold));
      n_rst = 0;
      pins_u.flip(0);
      wake(SD);
      chk("rst_seen", 32'h1, 32'(n_rst > 0));
      rd(pmc_pkg::OFS_CAUSE, 32'h4, 2'h0);
      rd(pmc_pkg::OFS_RAMRET, 32'hF, 2'h0);
      rd(pmc_pkg::OFS_WKPIN, 32'h0, 2'h0);
      // Held: only the reset pin wakes
      go(32'h4);
      pins_u.pulse(1);
      repeat (SD + 5) @(posedge clk);
      chk("held", 32'h1, 32'(hold));
      pins_u.rst_pin();
      wake(SD);
      rd(pmc_pkg::OFS_CAUSE, 32'h2, 2'h0);
      close_out();
   end
endmodule // pmc_ctrl_tb_top
